// File: logic/spiee_core.sv
// Purpose: Serial EEPROM array read and write command logic with its array.
// Assumes: SPI pins are asynchronous and much slower than clk_i.
// Notes: The serial clock is sampled; no logic runs on it.
`include "spiee_map.svh"

module spiee_core #(
    parameter int ADDR_W = `SPIEE_ADDR_BITS,
    parameter int PAGE_W = `SPIEE_PAGE_BITS,
    parameter int FIFO_DEPTH = `SPIEE_FIFO_DEPTH,
    parameter int PROG_CYCLES = `SPIEE_PROG_CYCLES
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic cs_n_i,
    input wire logic sck_i,
    input wire logic mosi_i,
    output logic miso_o,
    output logic miso_oe_o,
    input wire logic nv_load_i,
    input wire logic [1:0] block_protect_i,
    input wire logic status_write_disable_i,
    output logic [1:0] block_protect_o,
    output logic status_write_disable_o,
    output logic write_in_progress_flag_o,
    output logic write_enable_latch_o
);
    localparam int PAGE_BYTES = 1 << PAGE_W;
    localparam int CNT_W = $clog2(PROG_CYCLES + 1);

    if (ADDR_W > 16 || ADDR_W < PAGE_W + 2 || PAGE_W < 1 || PROG_CYCLES < PAGE_BYTES + 1) begin : g_bad
        $error("spiee_core: unsupported address, page or program cycle size.");
    end

    // Reset release, array and page buffer.
    logic [1:0] rst_pipe_reg;
    wire rst_n = rst_pipe_reg[1];
    logic [7:0] mem [1 << ADDR_W] = '{default: `SPIEE_ERASED_BYTE}; // [R18]
    logic [7:0] page_buf [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] page_mask_reg;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_pipe_reg <= 2'h0;
        end else begin
            rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
        end
    end

    // Pin synchronisers and edge detection.
    logic cs_s;
    logic sck_s;
    logic mosi_s;
    logic cs_prev_reg;
    logic sck_prev_reg;
    logic armed_reg;

    spiee_sync #(.RST_VAL(1'b1)) u_sync_cs (.clk_i(clk_i), .rst_n_i(rst_n), .d_i(cs_n_i), .q_o(cs_s));
    spiee_sync #(.RST_VAL(1'b0)) u_sync_sck (.clk_i(clk_i), .rst_n_i(rst_n), .d_i(sck_i), .q_o(sck_s));
    spiee_sync #(.RST_VAL(1'b0)) u_sync_mosi (.clk_i(clk_i), .rst_n_i(rst_n), .d_i(mosi_i), .q_o(mosi_s));

    wire cs_fall = cs_prev_reg & ~cs_s & armed_reg; // [R15]
    wire cs_rise = ~cs_prev_reg & cs_s;
    wire sck_rise = ~sck_prev_reg & sck_s & ~cs_s; // [R21]
    wire sck_fall = sck_prev_reg & ~sck_s & ~cs_s; // [R21]

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cs_prev_reg <= 1'b1;
            sck_prev_reg <= 1'b0;
            armed_reg <= 1'b0;
        end else begin
            cs_prev_reg <= cs_s;
            sck_prev_reg <= sck_s;
            armed_reg <= armed_reg | cs_s; // [R15]
        end
    end

    // Receive shifter, MSB first.
    logic [7:0] rx_sh_reg;
    logic [2:0] bit_cnt_reg;
    wire [7:0] rx_byte = {rx_sh_reg[6:0], mosi_s};
    wire byte_done = sck_rise & (bit_cnt_reg == 3'h7);

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rx_sh_reg <= 8'h00;
            bit_cnt_reg <= 3'h0;
        end else if (cs_fall) begin
            bit_cnt_reg <= 3'h0;
        end else if (sck_rise) begin
            rx_sh_reg <= rx_byte; // [R21]
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
        end
    end

    // Command decode and protection.
    spiee_pkg::spiee_state_t state_reg;
    logic op_write_reg;
    logic latch_val_reg;
    logic data_seen_reg;
    logic [7:0] addr_hi_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [CNT_W-1:0] prog_cnt_reg;
    logic [PAGE_W:0] prog_idx_reg;
    logic [ADDR_W-PAGE_W-1:0] prog_page_reg;
    logic [1:0] bp_reg = `SPIEE_BP_RESET; // [R18]
    logic swd_reg = `SPIEE_SWD_RESET;

    wire is_read = rx_byte == `SPIEE_CMD_READ;
    wire is_write = rx_byte == `SPIEE_CMD_WRITE;
    wire is_wr_enable = rx_byte == `SPIEE_CMD_WR_ENABLE;
    wire is_wrdis = rx_byte == `SPIEE_CMD_WRDIS;
    wire [15:0] addr_in = {addr_hi_reg, rx_byte};
    wire [ADDR_W-1:0] addr_new = addr_in[ADDR_W-1:0];
    wire [1:0] addr_top = addr_new[ADDR_W-1:ADDR_W-2];
    wire protect = (bp_reg == 2'h3) | ((bp_reg == 2'h2) & addr_top[1]) | ((bp_reg == 2'h1) & (addr_top == 2'h3));
    wire commit = cs_rise & (state_reg == spiee_pkg::ST_WRITE) & (bit_cnt_reg == 3'h0) & data_seen_reg;
    wire latch_go = cs_rise & (state_reg == spiee_pkg::ST_LATCH) & (bit_cnt_reg == 3'h0);
    wire prog_done = write_in_progress_flag_o & (prog_cnt_reg == CNT_W'(PROG_CYCLES - 1));
    wire prog_copy = write_in_progress_flag_o & ~prog_idx_reg[PAGE_W];
    wire wr_byte = (state_reg == spiee_pkg::ST_WRITE) & byte_done;
    wire [PAGE_W-1:0] addr_lo_inc = addr_reg[PAGE_W-1:0] + PAGE_W'(1);

    // Read prefetch path.
    logic [ADDR_W-1:0] fetch_addr_reg;
    logic [2:0] tx_cnt_reg;
    logic [7:0] tx_sh_reg;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [7:0] fifo_out_data;
    wire in_read = state_reg == spiee_pkg::ST_READ;
    wire fetch_valid = in_read & ~cs_s;
    wire fetch_push = fetch_valid & fifo_in_ready;
    wire tx_pop = in_read & sck_fall & (tx_cnt_reg == 3'h0);
    wire [7:0] tx_byte = fifo_out_valid ? fifo_out_data : `SPIEE_ERASED_BYTE;
    wire enter_read = (state_reg == spiee_pkg::ST_ADDR_LO) & byte_done & ~op_write_reg;

    spiee_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .flush_i(cs_rise | enter_read),
        .in_valid_i(fetch_valid),
        .in_ready_o(fifo_in_ready),
        .in_data_i(mem[fetch_addr_reg]),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(tx_pop),
        .out_data_o(fifo_out_data)
    );

    // Sequencer.
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= spiee_pkg::ST_IDLE; // [R15]
            op_write_reg <= 1'b0;
            latch_val_reg <= 1'b0;
            data_seen_reg <= 1'b0;
            addr_hi_reg <= 8'h00;
        end else if (cs_rise) begin
            state_reg <= spiee_pkg::ST_IDLE; // [R4]
        end else begin
            case (state_reg)
                spiee_pkg::ST_IDLE: begin
                    if (cs_fall) begin
                        state_reg <= spiee_pkg::ST_CMD;
                    end
                end
                spiee_pkg::ST_CMD: begin
                    if (byte_done) begin
                        op_write_reg <= is_write;
                        latch_val_reg <= is_wr_enable;
                        data_seen_reg <= 1'b0;
                        if (write_in_progress_flag_o) begin
                            state_reg <= spiee_pkg::ST_SKIP; // [R6] [R12]
                        end else if (is_read) begin
                            state_reg <= spiee_pkg::ST_ADDR_HI; // [R1]
                        end else if (is_write) begin
                            state_reg <= write_enable_latch_o ? spiee_pkg::ST_ADDR_HI : spiee_pkg::ST_SKIP; // [R11] [R20]
                        end else if (is_wr_enable | is_wrdis) begin
                            state_reg <= spiee_pkg::ST_LATCH;
                        end else begin
                            state_reg <= spiee_pkg::ST_SKIP;
                        end
                    end
                end
                spiee_pkg::ST_ADDR_HI: begin
                    if (byte_done) begin
                        addr_hi_reg <= rx_byte;
                        state_reg <= spiee_pkg::ST_ADDR_LO;
                    end
                end
                spiee_pkg::ST_ADDR_LO: begin
                    if (byte_done) begin
                        if (!op_write_reg) begin
                            state_reg <= spiee_pkg::ST_READ; // [R5]
                        end else if (protect) begin
                            state_reg <= spiee_pkg::ST_SKIP; // [R14]
                        end else begin
                            state_reg <= spiee_pkg::ST_WRITE; // [R7]
                        end
                    end
                end
                spiee_pkg::ST_WRITE: begin
                    if (byte_done) begin
                        data_seen_reg <= 1'b1;
                    end
                end
                default: begin
                    state_reg <= state_reg;
                end
            endcase
        end
    end

    // Address pointer: full wrap on reads, in-page wrap on writes.
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            addr_reg <= '0;
            fetch_addr_reg <= '0;
        end else if ((state_reg == spiee_pkg::ST_ADDR_LO) && byte_done) begin
            addr_reg <= addr_new; // [R1] [R5]
            fetch_addr_reg <= addr_new;
        end else begin
            if (wr_byte) begin
                addr_reg <= {addr_reg[ADDR_W-1:PAGE_W], addr_lo_inc}; // [R9] [R10]
            end else if (tx_pop) begin
                addr_reg <= addr_reg + ADDR_W'(1); // [R2] [R3]
            end
            if (fetch_push) begin
                fetch_addr_reg <= fetch_addr_reg + ADDR_W'(1); // [R3]
            end
        end
    end

    // Page buffer capture and array programming.
    always_ff @(posedge clk_i) begin
        if (wr_byte) begin
            page_buf[addr_reg[PAGE_W-1:0]] <= rx_byte; // [R10]
        end
        if (prog_copy && page_mask_reg[prog_idx_reg[PAGE_W-1:0]]) begin
            mem[{prog_page_reg, prog_idx_reg[PAGE_W-1:0]}] <= page_buf[prog_idx_reg[PAGE_W-1:0]];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            page_mask_reg <= '0;
        end else if (enter_read | prog_done | ((state_reg == spiee_pkg::ST_CMD) & ~write_in_progress_flag_o)) begin
            page_mask_reg <= '0;
        end else if (wr_byte) begin
            page_mask_reg[addr_reg[PAGE_W-1:0]] <= 1'b1;
        end
    end

    // Program timer, busy flag and write enable latch.
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            write_in_progress_flag_o <= 1'b0; // [R16]
            write_enable_latch_o <= 1'b0; // [R16]
            prog_cnt_reg <= '0;
            prog_idx_reg <= '0;
            prog_page_reg <= '0;
        end else if (commit) begin
            write_in_progress_flag_o <= 1'b1; // [R8] [R19]
            prog_cnt_reg <= '0;
            prog_idx_reg <= '0;
            prog_page_reg <= addr_reg[ADDR_W-1:PAGE_W];
        end else if (prog_done) begin
            write_in_progress_flag_o <= 1'b0; // [R8] [R19]
            write_enable_latch_o <= 1'b0; // [R22]
        end else if (write_in_progress_flag_o) begin
            prog_cnt_reg <= prog_cnt_reg + CNT_W'(1);
            prog_idx_reg <= prog_idx_reg + (PAGE_W+1)'(prog_copy);
        end else if (latch_go) begin
            write_enable_latch_o <= latch_val_reg; // [R20]
        end
    end

    // Serial output, changed on falling edges only.
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            miso_o <= 1'b0;
            miso_oe_o <= 1'b0;
            tx_cnt_reg <= 3'h0;
            tx_sh_reg <= 8'h00;
        end else if (cs_rise | ~in_read) begin
            miso_oe_o <= 1'b0; // [R4]
            tx_cnt_reg <= 3'h0;
        end else if (sck_fall) begin
            miso_oe_o <= 1'b1;
            if (tx_cnt_reg == 3'h0) begin
                miso_o <= tx_byte[7]; // [R1] [R21]
                tx_sh_reg <= {tx_byte[6:0], 1'b0};
            end else begin
                miso_o <= tx_sh_reg[7];
                tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
            end
            tx_cnt_reg <= tx_cnt_reg + 3'h1;
        end
    end

    // Non-volatile protection bits: never touched by reset.
    always_ff @(posedge clk_i) begin
        if (nv_load_i) begin
            bp_reg <= block_protect_i; // [R17]
            swd_reg <= status_write_disable_i;
        end
        block_protect_o <= bp_reg;
        status_write_disable_o <= swd_reg;
    end

    // Checks.
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n);

    a_read_busy_skip: assert property ((state_reg == spiee_pkg::ST_CMD) && byte_done && write_in_progress_flag_o
        |=> state_reg == spiee_pkg::ST_SKIP) else $error("Instruction accepted during program cycle."); // [R6]
    a_write_latch_gate: assert property ((state_reg == spiee_pkg::ST_CMD) && byte_done && is_write
        && !write_enable_latch_o |=> state_reg == spiee_pkg::ST_SKIP) else $error("Write taken without latch."); // [R11]
    a_protect_reject: assert property ((state_reg == spiee_pkg::ST_ADDR_LO) && byte_done && op_write_reg && protect
        |=> state_reg == spiee_pkg::ST_SKIP) else $error("Write to protected page accepted."); // [R14]
    a_prog_start: assert property (commit && !write_in_progress_flag_o
        |=> write_in_progress_flag_o && $stable(write_enable_latch_o)) else $error("Program cycle not started."); // [R8]
    a_partial_discard: assert property (cs_rise && (state_reg == spiee_pkg::ST_WRITE) && (bit_cnt_reg != 3'h0)
        && !write_in_progress_flag_o |=> !write_in_progress_flag_o) else $error("Partial byte write programmed."); // [R13]
    a_page_wrap: assert property (wr_byte |=> addr_reg[PAGE_W-1:0] == $past(addr_lo_inc)
        && $stable(addr_reg[ADDR_W-1:PAGE_W])) else $error("Write address left its page."); // [R10]
    a_read_advance: assert property (tx_pop |=> addr_reg == $past(addr_reg) + ADDR_W'(1))
        else $error("Read pointer did not advance."); // [R2]
    a_cs_stop: assert property (cs_rise |=> state_reg == spiee_pkg::ST_IDLE ##1 !miso_oe_o)
        else $error("Transfer not ended by chip select."); // [R4]
    a_prog_end: assert property (prog_done |=> !write_in_progress_flag_o && !write_enable_latch_o)
        else $error("Program cycle end not reported."); // [R22]

    a_mask_hold: assert property (write_in_progress_flag_o && !prog_done |=> $stable(page_mask_reg))
        else $error("Page buffer mask lost during program cycle."); // [R8]
    a_latch_set: assert property (latch_go && !write_in_progress_flag_o |=> write_enable_latch_o == $past(latch_val_reg))
        else $error("Write enable latch not updated."); // [R20]

    c_read_two: cover property (tx_pop ##[1:200] tx_pop);
    c_commit: cover property (commit);
    c_prog_done: cover property (prog_done);
    c_read_wrap: cover property (tx_pop && (addr_reg == '1));
endmodule // spiee_core

// File: logic/spiee_map.svh
// Purpose: Constants of the serial EEPROM array read and write logic.
// Assumes: Included by the design files by its bare name.
// Notes: Definitions only.
// What this block does
// R1 - Read: chip select low, instruction, two address bytes, then addressed data out.
// R2 - During a read the pointer advances after each byte sent.
// R3 - Read pointer wraps from the top location to zero.
// R4 - Raising chip select ends any transfer cleanly at any point.
// R5 - Any byte of any page is a legal read start.
// R6 - A read arriving during a program cycle is ignored.
// R7 - Write: chip select low, instruction, address, one or more data bytes.
// R8 - Chip select rising at a byte boundary starts a timed program cycle.
// R9 - Each further data byte increments only the in-page address bits.
// R10 - Bytes beyond the page end wrap to page start and overwrite.
// R11 - A write is rejected unless the write enable latch is set.
// R12 - A write arriving during a program cycle is rejected.
// R13 - A write ending off a byte boundary is discarded.
// R14 - A write to a page inside the protected region is rejected.
// R15 - After power-up the block waits deselected for a chip select fall.
// R16 - Power-up clears the write enable latch and the busy flag.
// R17 - Protection and disable bits keep their values across power cycles.
// R18 - Delivered state: array reads all ones, protection bits zero.
// R19 - The busy flag is high exactly while a program cycle runs.
// R20 - The enable instruction sets the latch; a clear latch blocks writes.
// R21 - Input sampled on rising clock edges, output on falling edges, MSB first.
// R22 - The write enable latch clears when a program cycle completes.
`ifndef SPIEE_MAP_SVH
`define SPIEE_MAP_SVH
`define SPIEE_CMD_WRITE 8'h02
`define SPIEE_CMD_READ 8'h03
`define SPIEE_CMD_WRDIS 8'h04
`define SPIEE_CMD_WR_ENABLE 8'h06
`define SPIEE_ERASED_BYTE 8'hff
`define SPIEE_BP_RESET 2'h0
`define SPIEE_SWD_RESET 1'h0
`define SPIEE_ADDR_BITS 16
`define SPIEE_PAGE_BITS 7
`define SPIEE_FIFO_DEPTH 16
`define SPIEE_CLK_MHZ 10
`define SPIEE_PROG_TIME_US 5000
`define SPIEE_PROG_CYCLES (`SPIEE_PROG_TIME_US * `SPIEE_CLK_MHZ)
`endif

// File: logic/spiee_pkg.sv
// Purpose: Types of the serial EEPROM array read and write logic.
// Assumes: Constants live in spiee_map.svh.
// Notes: Command sequencer states.
package spiee_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_CMD = 3'h1,
        ST_ADDR_HI = 3'h2,
        ST_ADDR_LO = 3'h3,
        ST_READ = 3'h4,
        ST_WRITE = 3'h5,
        ST_LATCH = 3'h6,
        ST_SKIP = 3'h7
    } spiee_state_t;
endpackage

// File: logic/spiee_sync.sv
// Purpose: Two flip-flop synchroniser for one pin.
// Assumes: The pin is asynchronous to clk_i.
// Notes: Only the second stage is visible outside.
module spiee_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic d_i,
    output logic q_o
);
    logic meta_reg;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_reg <= RST_VAL;
            q_o <= RST_VAL;
        end else begin
            meta_reg <= d_i;
            q_o <= meta_reg;
        end
    end
endmodule // spiee_sync

// File: logic/spiee_fifo.sv
// Purpose: Small FIFO with valid and ready on both sides and a flush.
// Assumes: DEPTH is a power of two.
// Notes: Flush empties it in one cycle.
module spiee_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic flush_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr_reg;
    logic [AW:0] rd_ptr_reg;
    wire push = in_valid_i & in_ready_o;
    wire pop = out_valid_o & out_ready_i;

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("spiee_fifo: DEPTH must be a power of two of at least 2.");
    end

    assign in_ready_o = (wr_ptr_reg ^ rd_ptr_reg) != {1'b1, {AW{1'b0}}};
    assign out_valid_o = wr_ptr_reg != rd_ptr_reg;
    assign out_data_o = mem[rd_ptr_reg[AW-1:0]];

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr_reg[AW-1:0]] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else if (flush_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_reg + (AW+1)'(push);
            rd_ptr_reg <= rd_ptr_reg + (AW+1)'(pop);
        end
    end
endmodule // spiee_fifo

// File: testbench/spiee_host_model.sv
// Purpose: SPI host model that drives chip select, serial clock and serial data in.
// Assumes: Mode 0 with an 800 ns serial clock made from the 100 ns system clock.
// Notes: The serial clock stands low outside frames; a released data out line toggles.
module spiee_host_model (
    input wire logic clk_i,
    input wire logic miso_i,
    input wire logic miso_oe_i,
    output logic cs_n_o,
    output logic sck_o,
    output logic mosi_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic last_bit = 1'b0;
    logic miso_line;
    assign miso_line = miso_oe_i ? miso_i : ~last_bit;
    always @(posedge clk_i) begin
        last_bit <= miso_line;
    end
    initial begin
        cs_n_o = 1'b1;
        sck_o = 1'b0;
        mosi_o = 1'b0;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    task automatic select();
        wait_clk(2);
        cs_n_o = 1'b0;
        wait_clk(2);
    endtask
    task automatic deselect();
        wait_clk(2);
        cs_n_o = 1'b1;
        mosi_o = ~mosi_o;
        wait_clk(6);
    endtask
    task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - n; i--) begin
            mosi_o = tx[i];
            wait_clk(5);
            rx[i] = miso_line;
            sck_o = 1'b1;
            wait_clk(3);
            sck_o = 1'b0;
        end
    endtask
endmodule // spiee_host_model

// File: testbench/tb_serial_eeprom_array_read_write.sv
// Purpose: Self-checking bench of the serial EEPROM read and write logic.
// Assumes: The program cycle is shortened to PC clocks.
// Notes: A reference array, all ones by default, predicts every read.
`include "spiee_map.svh"

module tb_serial_eeprom_array_read_write;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int PC = 1000;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic cs_n, sck, mosi, miso, miso_oe, swd_out, busy, wr_latch;
    logic nv_load = 1'b0;
    logic swd_in = 1'b0;
    logic [1:0] bp_in = 2'h0;
    logic [1:0] bp_out;
    logic [7:0] rx;
    logic [7:0] ref_mem [logic [15:0]];
    time t_commit;
    int mismatches = 0;
    int cmp_count = 0;
    initial begin
        forever #50 clk_i = ~clk_i;
    end
    spiee_core #(.PROG_CYCLES(PC)) dut_u (.clk_i(clk_i), .rstn_i(rstn_i), .cs_n_i(cs_n), .sck_i(sck),
        .mosi_i(mosi), .miso_o(miso), .miso_oe_o(miso_oe), .nv_load_i(nv_load), .block_protect_i(bp_in),
        .status_write_disable_i(swd_in), .block_protect_o(bp_out), .status_write_disable_o(swd_out),
        .write_in_progress_flag_o(busy), .write_enable_latch_o(wr_latch));
    spiee_host_model host_u (.clk_i(clk_i), .miso_i(miso), .miso_oe_i(miso_oe), .cs_n_o(cs_n), .sck_o(sck),
        .mosi_o(mosi));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [7:0] ref_at(input logic [15:0] a);
        return ref_mem.exists(a) ? ref_mem[a] : `SPIEE_ERASED_BYTE;
    endfunction
    task automatic send_cmd(input logic [7:0] op, input logic [15:0] a);
        host_u.select();
        host_u.xfer(op, 8, rx);
        host_u.xfer(a[15:8], 8, rx);
        host_u.xfer(a[7:0], 8, rx);
    endtask
    task automatic short_cmd(input logic [7:0] op);
        host_u.select();
        host_u.xfer(op, 8, rx);
        host_u.deselect();
    endtask
    task automatic read_check(input logic [15:0] a, input int n);
        send_cmd(`SPIEE_CMD_READ, a);
        for (int i = 0; i < n; i++) begin
            host_u.xfer(8'h00, 8, rx);
            check(rx, ref_at(16'(a + 16'(i))));
        end
        host_u.deselect();
    endtask
    task automatic write_bytes(input logic [15:0] a, input int n, input logic [7:0] v, input bit en, input bit upd);
        if (en) short_cmd(`SPIEE_CMD_WR_ENABLE);
        send_cmd(`SPIEE_CMD_WRITE, a);
        for (int i = 0; i < n; i++) begin
            host_u.xfer(8'(v + 8'(i)), 8, rx);
            if (upd) ref_mem[{a[15:7], 7'(a[6:0] + 7'(i))}] = 8'(v + 8'(i));
        end
        host_u.deselect();
        if (upd) t_commit = $time;
    endtask
    task automatic wait_prog();
        int el;
        while (busy === 1'b1 && $time - t_commit < 2 * PC * 100) @(negedge clk_i);
        el = int'(($time - t_commit) / 100);
        check({7'h0, busy}, 8'h00);
        check({7'h0, el >= PC - 10 && el <= PC + 10}, 8'h01);
        check({7'h0, wr_latch}, 8'h00);
    endtask
    task automatic t_power();
        check({6'h0, busy, wr_latch}, 8'h00);
        check({5'h0, swd_out, bp_out}, 8'h00);
        check({7'h0, miso_oe}, 8'h00);
        read_check(16'h1234, 3);
    endtask
    task automatic t_page();
        short_cmd(`SPIEE_CMD_WR_ENABLE);
        check({7'h0, wr_latch}, 8'h01);
        write_bytes(16'hfffe, 129, 8'h00, 1'b0, 1'b1);
        check({7'h0, busy}, 8'h01);
        send_cmd(`SPIEE_CMD_READ, 16'hfffe);
        host_u.xfer(8'h00, 8, rx);
        check({7'h0, miso_oe}, 8'h00);
        host_u.deselect();
        write_bytes(16'h2000, 1, 8'h77, 1'b0, 1'b0);
        wait_prog();
        read_check(16'hfffe, 4);
        read_check(16'hff80, 2);
        read_check(16'h2000, 1);
    endtask
    task automatic t_reject();
        write_bytes(16'h0100, 1, 8'h11, 1'b0, 1'b0);
        check({7'h0, busy}, 8'h00);
        short_cmd(`SPIEE_CMD_WR_ENABLE);
        send_cmd(`SPIEE_CMD_WRITE, 16'h0100);
        host_u.xfer(8'h22, 8, rx);
        host_u.xfer(8'h33, 4, rx);
        host_u.deselect();
        check({7'h0, busy}, 8'h00);
        write_bytes(16'h0100, 0, 8'h00, 1'b1, 1'b0);
        check({7'h0, busy}, 8'h00);
        short_cmd(`SPIEE_CMD_WR_ENABLE);
        short_cmd(`SPIEE_CMD_WRDIS);
        check({7'h0, wr_latch}, 8'h00);
        nv_load = 1'b1;
        bp_in = 2'h1;
        @(negedge clk_i);
        nv_load = 1'b0;
        @(negedge clk_i);
        check({6'h0, bp_out}, 8'h01);
        write_bytes(16'hc000, 1, 8'h44, 1'b1, 1'b0);
        check({7'h0, busy}, 8'h00);
        write_bytes(16'hbfff, 1, 8'h55, 1'b1, 1'b1);
        check({7'h0, busy}, 8'h01);
        wait_prog();
        read_check(16'hbfff, 2);
        read_check(16'h0100, 1);
    endtask
    task automatic t_abort();
        send_cmd(`SPIEE_CMD_READ, 16'hfffe);
        host_u.xfer(8'h00, 3, rx);
        host_u.deselect();
        check({7'h0, miso_oe}, 8'h00);
        read_check(16'hffff, 2);
    endtask
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(negedge clk_i);
        rstn_i = 1'b1;
        repeat (8) @(negedge clk_i);
        t_power();
        t_page();
        t_reject();
        t_abort();
        give_verdict();
    end
    initial begin
        #6000000;
        mismatches++;
        give_verdict();
    end
endmodule // tb_serial_eeprom_array_read_write
